// >>> rtl/oup_pkg.sv
package oup_pkg;

  // bus widths and channel layout
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_CHAN = 8;
  localparam int REGS_PER_CHAN = 16;
  localparam int NUM_GLB_REGS = 16;

  // address field positions
  localparam int REG_LSB = 0;
  localparam int REG_W = 4;
  localparam int CHAN_LSB = 4;
  localparam int CHAN_W = 3;
  localparam int GLOBAL_BIT = 7;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  // global register offsets
  localparam logic [3:0] GLB_INT_SRC_OFS = 4'h0;

  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET = 8'h00;

  // packed pin bundle: mode select, chip select, read, write, address, data
  localparam int PIN_W = 4 + ADDR_W + DATA_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_FETCH,
    ST_RD_LATCH,
    ST_RD_DRIVE,
    ST_WR_HOLD
  } oup_state_t;

  typedef struct packed {
    logic rdAct;
    logic wrAct;
  } oup_access_t;

  typedef struct packed {
    oup_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic dataOeN;
    logic intOeN;
    logic cfgWrite;
    logic cfgRead;
    logic prevRdAct;
    logic prevWrAct;
  } oup_port_state_t;

  localparam oup_port_state_t PORT_RESET = '{
    state: ST_IDLE,
    addr: ADDR_RESET,
    wrData: REG_RESET,
    rdData: REG_RESET,
    dataOeN: 1'b1,
    intOeN: 1'b1,
    default: 1'b0
  };

  typedef struct packed {
    logic [NUM_CHAN*REGS_PER_CHAN-1:0][DATA_W-1:0] chanMem;
    logic [NUM_GLB_REGS-1:0][DATA_W-1:0] glbMem;
    logic [DATA_W-1:0] rdData;
  } oup_regs_state_t;

  // address targets the global register page
  function automatic logic isGlobal(input logic [ADDR_W-1:0] a);
    isGlobal = a[GLOBAL_BIT];
  endfunction : isGlobal

  // flat index of a channel register: channel field above register field
  function automatic logic [CHAN_W+REG_W-1:0] chanIndex(input logic [ADDR_W-1:0] a);
    chanIndex = {a[CHAN_LSB +: CHAN_W], a[REG_LSB +: REG_W]};
  endfunction : chanIndex

endpackage : oup_pkg

// >>> rtl/oup_reg_if.sv
`timescale 1ns/10ps
interface oup_reg_if;
  logic wrEn;
  logic rdEn;
  logic [oup_pkg::ADDR_W-1:0] addr;
  logic [oup_pkg::DATA_W-1:0] wrData;
  logic [oup_pkg::DATA_W-1:0] rdData;

  modport port (output wrEn, output rdEn, output addr, output wrData, input rdData);
  modport regs (input wrEn, input rdEn, input addr, input wrData, output rdData);
endinterface : oup_reg_if

// >>> rtl/oup_sync.sv
`timescale 1ns/10ps
module oup_sync #(
  parameter int WIDTH = oup_pkg::PIN_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } oup_sync_state_t;

  oup_sync_state_t cur;
  oup_sync_state_t next_cur;

  // first stage feeds only the second stage
  always_comb begin
    next_cur.meta = asyncIn;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  assign syncOut = cur.stable;

endmodule : oup_sync

// >>> rtl/oup_regs.sv
`timescale 1ns/10ps
module oup_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // per-channel interrupt levels from the uart cores
  input wire logic [oup_pkg::NUM_CHAN-1:0] chanIrq,
  // access from the host port
  oup_reg_if.regs bus
);

  oup_pkg::oup_regs_state_t cur;
  oup_pkg::oup_regs_state_t next_cur;

  always_comb begin
    next_cur = cur;
    if (bus.wrEn) begin
      if (oup_pkg::isGlobal(bus.addr)) begin // [R2]
        // the interrupt source register is read only
        if (bus.addr[oup_pkg::REG_LSB +: oup_pkg::REG_W] != oup_pkg::GLB_INT_SRC_OFS) begin
          next_cur.glbMem[bus.addr[oup_pkg::REG_LSB +: oup_pkg::REG_W]] = bus.wrData;
        end
      end else begin
        next_cur.chanMem[oup_pkg::chanIndex(bus.addr)] = bus.wrData; // [R1]
      end
    end
    if (bus.rdEn) begin
      if (oup_pkg::isGlobal(bus.addr)) begin // [R2]
        if (bus.addr[oup_pkg::REG_LSB +: oup_pkg::REG_W] == oup_pkg::GLB_INT_SRC_OFS) begin
          next_cur.rdData = chanIrq; // [R11]
        end else begin
          next_cur.rdData = cur.glbMem[bus.addr[oup_pkg::REG_LSB +: oup_pkg::REG_W]];
        end
      end else begin
        next_cur.rdData = cur.chanMem[oup_pkg::chanIndex(bus.addr)]; // [R1]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.rdData = cur.rdData;

endmodule : oup_regs

// >>> rtl/oup_host_port.sv
// Operation
// R1 - low nibble register, next three bits channel
// R2 - top address bit selects global registers
// R3 - eight-bit two-way data bus
// R4 - separate mode: read strobe fall starts read
// R5 - direction mode: host ties read strobe high
// R6 - separate mode: write stored at strobe rise
// R7 - direction mode: write pin gives direction
// R8 - separate mode: chip select gates strobes
// R9 - direction mode: chip select is strobe
// R10 - open-drain active-low shared interrupt
// R11 - global register shows all channel interrupts
// R12 - direction mode: drive reads, capture at rise
`timescale 1ns/10ps
module oup_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // host bus style: high separate strobes, low direction plus strobe
  input wire logic hostBusModeSel,
  // host address and strobes
  input wire logic [oup_pkg::ADDR_W-1:0] host_address,
  input wire logic hostChipSelN,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  // host data bus, split
  input wire logic [oup_pkg::DATA_W-1:0] hostDataIn,
  output logic [oup_pkg::DATA_W-1:0] hostDataOut,
  output logic hostDataOeN,
  // shared interrupt line, split
  output logic hostIntOut,
  output logic hostIntOeN,
  // uart core side
  input wire logic [oup_pkg::NUM_CHAN-1:0] chanIrq
);

  logic [oup_pkg::PIN_W-1:0] pinsAsync;
  logic [oup_pkg::PIN_W-1:0] pinsSync;
  logic modeSel;
  logic csN;
  logic rdN;
  logic wrN;
  logic [oup_pkg::ADDR_W-1:0] pinAddr;
  logic [oup_pkg::DATA_W-1:0] pinData;
  oup_pkg::oup_access_t acc;
  oup_pkg::oup_port_state_t cur;
  oup_pkg::oup_port_state_t next_cur;

  oup_reg_if regBus ();

  // decode the strobe style into read and write activity
  function automatic oup_pkg::oup_access_t decodeAccess(
    input logic sepStrobes,
    input logic chipSelN,
    input logic readN,
    input logic writeN
  );
    oup_pkg::oup_access_t a;
    a = '0;
    if (sepStrobes) begin
      a.rdAct = !chipSelN && !readN; // [R8] [R4]
      a.wrAct = !chipSelN && !writeN; // [R8] [R6]
    end else begin
      // read strobe pin is not looked at in this style
      a.rdAct = !chipSelN && writeN; // [R9] [R7] [R5]
      a.wrAct = !chipSelN && !writeN; // [R9] [R7]
    end
    decodeAccess = a;
  endfunction : decodeAccess

  assign pinsAsync = {hostBusModeSel, hostChipSelN, host_read_strobe_n, host_write_strobe_n,
                      host_address, hostDataIn};

  oup_sync #(
    .WIDTH(oup_pkg::PIN_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(pinsAsync),
    .syncOut(pinsSync)
  );

  assign {modeSel, csN, rdN, wrN, pinAddr, pinData} = pinsSync;

  assign acc = decodeAccess(modeSel, csN, rdN, wrN);

  oup_regs u_regs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chanIrq(chanIrq),
    .bus(regBus)
  );

  assign regBus.rdEn = cur.cfgRead;
  assign regBus.wrEn = cur.cfgWrite;
  assign regBus.addr = cur.addr;
  assign regBus.wrData = cur.wrData;

  always_comb begin
    next_cur = cur;
    next_cur.cfgRead = 1'b0;
    next_cur.cfgWrite = 1'b0;
    next_cur.prevRdAct = acc.rdAct;
    next_cur.prevWrAct = acc.wrAct;
    // any channel interrupt pulls the shared line low
    next_cur.intOeN = ~(|chanIrq); // [R10]

    case (cur.state)
      oup_pkg::ST_IDLE: begin
        next_cur.dataOeN = 1'b1;
        if (acc.rdAct && !cur.prevRdAct) begin
          // leading edge of a read: fetch the addressed register
          next_cur.addr = pinAddr; // [R4] [R1] [R2]
          next_cur.cfgRead = 1'b1;
          next_cur.state = oup_pkg::ST_RD_FETCH;
        end else if (acc.wrAct && !cur.prevWrAct) begin
          // leading edge of a write: hold the address
          next_cur.addr = pinAddr; // [R6] [R1] [R2]
          next_cur.wrData = pinData;
          next_cur.state = oup_pkg::ST_WR_HOLD;
        end
      end

      oup_pkg::ST_RD_FETCH: begin
        // register file answers one cycle after the request
        next_cur.state = oup_pkg::ST_RD_LATCH;
      end

      oup_pkg::ST_RD_LATCH: begin
        next_cur.rdData = regBus.rdData;
        if (acc.rdAct) begin
          next_cur.dataOeN = 1'b0; // [R3] [R4] [R12]
          next_cur.state = oup_pkg::ST_RD_DRIVE;
        end else begin
          next_cur.state = oup_pkg::ST_IDLE;
        end
      end

      oup_pkg::ST_RD_DRIVE: begin
        // drive until the strobe or direction ends the read
        if (!acc.rdAct) begin
          next_cur.dataOeN = 1'b1; // [R3] [R12]
          next_cur.state = oup_pkg::ST_IDLE;
        end
      end

      oup_pkg::ST_WR_HOLD: begin
        if (acc.wrAct) begin
          // keep the last byte seen while the strobe is low
          next_cur.wrData = pinData; // [R3]
        end else begin
          // return edge of the strobe commits the byte
          next_cur.cfgWrite = 1'b1; // [R6] [R12]
          next_cur.state = oup_pkg::ST_IDLE;
        end
      end

      default: begin
        next_cur.dataOeN = 1'b1;
        next_cur.state = oup_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur <= oup_pkg::PORT_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign hostDataOut = cur.rdData;
  assign hostDataOeN = cur.dataOeN;
  // the line is only ever pulled low, never driven high
  assign hostIntOut = 1'b0; // [R10]
  assign hostIntOeN = cur.intOeN;

endmodule : oup_host_port

// >>> test/oup_host_model.sv
`timescale 1ns/10ps
module oup_host_model (
  // clock and style
  input wire logic ref_clk,
  input wire logic busMode,
  // device data bus
  input wire logic [7:0] dataOut,
  input wire logic dataOeN,
  // host pins
  output logic [7:0] addr,
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic [7:0] dataIn
);
  logic [7:0] hostDrv = 8'h00;
  logic hostDrives = 1'b0;
  initial begin
    addr = 8'h00;
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
  end
  // a released bus shows the inverse of the last host byte
  assign dataIn = !dataOeN ? dataOut : (hostDrives ? hostDrv : ~hostDrv);
  task automatic xfer(input logic isWr, input logic useCs, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic drv);
    q = 8'h00;
    drv = 1'b0;
    @(posedge ref_clk);
    addr <= a;
    hostDrv <= d;
    hostDrives <= isWr;
    csN <= !useCs;
    wrN <= !isWr;
    if (busMode) rdN <= isWr;
    for (int n = 0; n < 12 && !drv; n++) begin
      @(posedge ref_clk);
      if (dataOeN === 1'b0) begin
        q = dataOut;
        drv = 1'b1;
      end
    end
    csN <= 1'b1;
    rdN <= 1'b1;
    wrN <= 1'b1;
    repeat (3) @(posedge ref_clk);
    hostDrives <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : xfer
endmodule : oup_host_model

// >>> test/oup_host_port_sva.sv
`timescale 1ns/10ps
module oup_host_port_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // port pins
  input wire logic hostBusModeSel,
  input wire logic [7:0] host_address,
  input wire logic hostChipSelN,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOeN,
  input wire logic hostIntOut,
  input wire logic hostIntOeN,
  input wire logic [7:0] chanIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire rdReq = !hostChipSelN && (hostBusModeSel ? !host_read_strobe_n : host_write_strobe_n);
  property p_iod;
    hostIntOut == 1'b0;
  endproperty
  a_iod: assert property (p_iod) else $error("int pin high");
  property p_irq;
    1'b1 |=> hostIntOeN == !$past(|chanIrq);
  endproperty
  a_irq: assert property (p_irq) else $error("int enable wrong");
  property p_csoff;
    hostChipSelN [*6] |-> hostDataOeN;
  endproperty
  a_csoff: assert property (p_csoff) else $error("drive unselected");
  property p_src;
    $fell(hostDataOeN) |-> $past(rdReq, 3);
  endproperty
  a_src: assert property (p_src) else $error("drive without read");
  property p_lat;
    $rose(rdReq) ##1 rdReq [*5] |-> ##[0:2] !hostDataOeN;
  endproperty
  a_lat: assert property (p_lat) else $error("read not driven");
  property p_end;
    (hostBusModeSel && host_read_strobe_n) [*5] |-> hostDataOeN;
  endproperty
  a_end: assert property (p_end) else $error("drive after read");
  property p_wrnd;
    (!hostBusModeSel && !host_write_strobe_n) [*5] |-> hostDataOeN;
  endproperty
  a_wrnd: assert property (p_wrnd) else $error("drive in write");
  property p_hold;
    !hostDataOeN && !$past(hostDataOeN) |-> $stable(hostDataOut);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  c_rd: cover property ($fell(hostDataOeN) && hostBusModeSel);
  c_dir: cover property ($fell(hostDataOeN) && !hostBusModeSel);
  c_irq: cover property (!hostIntOeN);
endmodule : oup_host_port_sva
bind oup_host_port oup_host_port_sva oup_host_port_sva_inst (.ref_clk, .rst_n, .hostBusModeSel, .host_address,
  .hostChipSelN, .host_read_strobe_n, .host_write_strobe_n, .hostDataIn, .hostDataOut, .hostDataOeN,
  .hostIntOut, .hostIntOeN, .chanIrq);

// >>> test/oup_host_port_tb_top.sv
`timescale 1ns/10ps
module oup_host_port_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic busMode = 1'b1;
  logic [7:0] chanIrq = 8'h00;
  logic csN, rdN, wrN, dataOeN, intOut, intOeN, drv;
  logic [7:0] addr, dataIn, dataOut, q;
  int error_cnt = 0;
  int tests_run = 0;
  `define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
  always #20 ref_clk = ~ref_clk;
  oup_host_port oup_host_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .hostBusModeSel(busMode),
    .host_address(addr), .hostChipSelN(csN), .host_read_strobe_n(rdN), .host_write_strobe_n(wrN),
    .hostDataIn(dataIn), .hostDataOut(dataOut), .hostDataOeN(dataOeN), .hostIntOut(intOut),
    .hostIntOeN(intOeN), .chanIrq(chanIrq));
  oup_host_model oup_host_model_inst (.ref_clk(ref_clk), .busMode(busMode), .dataOut(dataOut),
    .dataOeN(dataOeN), .addr(addr), .csN(csN), .rdN(rdN), .wrN(wrN), .dataIn(dataIn));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    oup_host_model_inst.xfer(1'b1, 1'b1, a, d, q, drv);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    oup_host_model_inst.xfer(1'b0, 1'b1, a, 8'h00, q, drv);
  endtask : rd
  task automatic t_sep;
    wr(8'h5A, 8'h3C);
    wr(8'h2A, 8'hC3);
    wr(8'h8A, 8'h5A);
    rd(8'h5A);
    `CHK("ch5 reg", 8'h3C, q)
    rd(8'h2A);
    `CHK("ch2 reg", 8'hC3, q)
    rd(8'h8A);
    `CHK("global reg", 8'h5A, q)
  endtask : t_sep
  task automatic t_gate;
    oup_host_model_inst.xfer(1'b1, 1'b0, 8'h25, 8'hFF, q, drv);
    oup_host_model_inst.xfer(1'b0, 1'b0, 8'h25, 8'h00, q, drv);
    `CHK("unselected drive", 1'b0, drv)
    rd(8'h25);
    `CHK("unselected write", 8'h00, q)
  endtask : t_gate
  task automatic t_irq;
    @(posedge ref_clk) chanIrq <= 8'hA5;
    rd(8'h80);
    `CHK("int source", 8'hA5, q)
    `CHK("int enable", 1'b0, intOeN)
    `CHK("int level", 1'b0, intOut)
    wr(8'h80, 8'h00);
    rd(8'h80);
    `CHK("int source kept", 8'hA5, q)
    @(posedge ref_clk) chanIrq <= 8'h00;
    repeat (2) @(posedge ref_clk);
    `CHK("int released", 1'b1, intOeN)
  endtask : t_irq
  task automatic t_dir;
    @(posedge ref_clk) busMode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(8'h37, 8'h96);
    rd(8'h37);
    `CHK("dir mode reg", 8'h96, q)
    rd(8'h5A);
    `CHK("dir mode ch5", 8'h3C, q)
  endtask : t_dir
  task automatic t_rst;
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("reset drive", 1'b1, dataOeN)
    `CHK("reset int", 1'b1, intOeN)
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h5A);
    `CHK("reset ch5", 8'h00, q)
    rd(8'h8A);
    `CHK("reset global", 8'h00, q)
  endtask : t_rst
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_sep();
    t_gate();
    t_irq();
    t_dir();
    t_rst();
    end_of_test();
  end
endmodule : oup_host_port_tb_top
